/* File: src/dual_comparator_control.sv */
// control, result, change flag and interrupt logic around two analog comparators
//
// Contract
// - result is one when selected positive input exceeds negative; readable, optionally pinned
// - positive input picks one of two pins; negative picks pin or internal reference
// - two comparators, each with its own identically laid out control register
// - positive choice, negative choice and pin enable select one of eight configurations
// - change flag sets whenever the comparator output changes in either direction
// - interrupt only while flag, per-comparator enable and global enable are all set
// - enabled comparators keep working and flagging during idle and power down
// - an enabled output change in idle or power down wakes the processor
// - change flag is bit zero, cleared by writing zero to it; the same write also loads bits 5 to 2 but not the result bit
// - writing 24h enables comparator one on pin a, external reference, pin driven
// - internal reference can serve as negative input for single-pin use; reset selects the external pin
`timescale 1ns/1ps
`include "dual_cmp_cfg.svh"
module dual_comparator_control
   import dual_cmp_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_comparator_one_control_wr,
   input  wire logic       i_comparator_two_control_wr,
   input  wire logic [7:0] i_control_wdata,
   input  wire logic [1:0] i_analog_result,
   input  wire logic [1:0] i_comparator_irq_enable,
   input  wire logic       i_global_irq_enable,
   input  wire logic       i_idle,
   input  wire logic       i_power_down,
   output logic [7:0]      o_comparator_one_control,
   output logic [7:0]      o_comparator_two_control,
   output logic [1:0]      o_analog_enable,
   output logic [1:0]      o_positive_input_select,
   output logic [1:0]      o_negative_input_select,
   output logic            o_internal_ref_enable,
   output logic [1:0]      o_result_pin,
   output logic [1:0]      o_result_pin_oe,
   output logic [1:0]      o_irq,
   output logic            o_wake,
   output logic [1:0]      o_settled
);

   // ***************************
   // per-comparator state
   // ***************************
   logic [1:0]    ctrl_wr;
   logic [1:0]    enable;
   logic [1:0]    positive_input_select;
   logic [1:0]    negative_input_select;
   logic [1:0]    result_pin_enable;
   logic [1:0]    result;
   logic [1:0]    output_change_flag;
   logic [1:0]    accepted;
   logic [1:0]    next_result;
   logic [1:0]    change;
   settle_count_t settle_count [1:0];

   assign ctrl_wr = {i_comparator_two_control_wr, i_comparator_one_control_wr};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_cmp

         comparator_input_sync u_sync (
            .i_clk    (i_clk),
            .i_arst_n (i_arst_n),
            .i_raw    (i_analog_result[ch]),
            .o_level  (accepted[ch])
         );

         // ***************************
         // configuration bits
         // ***************************
         // enable, input choices and pin enable; a write of 24h lands here as well
         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               enable[ch]                <= 1'b0;
               positive_input_select[ch] <= POS_PIN_A;
               negative_input_select[ch] <= NEG_EXT_PIN;
               result_pin_enable[ch]     <= 1'b0;
            end else if (ctrl_wr[ch]) begin
               enable[ch]                <= i_control_wdata[`CMP_EN_BIT];
               positive_input_select[ch] <= i_control_wdata[`CMP_POS_BIT];
               negative_input_select[ch] <= i_control_wdata[`CMP_NEG_BIT];
               result_pin_enable[ch]     <= i_control_wdata[`CMP_OE_BIT];
            end
         end

         // ***************************
         // result and change detection
         // ***************************
         // a disabled comparator reads zero; the analog core compares pos against neg
         assign next_result[ch] = enable[ch] & accepted[ch];
         assign change[ch]      = next_result[ch] ^ result[ch];

         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               result[ch] <= 1'b0;
            end else begin
               result[ch] <= next_result[ch];
            end
         end

         // ***************************
         // change flag
         // ***************************
         // a change in the same cycle as a clearing write keeps the flag set
         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               output_change_flag[ch] <= 1'b0;
            end else if (change[ch]) begin
               output_change_flag[ch] <= 1'b1;
            end else if (ctrl_wr[ch] && !i_control_wdata[`CMP_FLAG_BIT]) begin
               output_change_flag[ch] <= 1'b0;
            end
         end

         // ***************************
         // result pin
         // ***************************
         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               o_result_pin[ch]    <= 1'b0;
               o_result_pin_oe[ch] <= 1'b0;
            end else begin
               o_result_pin[ch]    <= next_result[ch];
               o_result_pin_oe[ch] <= enable[ch] & result_pin_enable[ch];
            end
         end

         // ***************************
         // analog front end controls
         // ***************************
         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               o_analog_enable[ch]         <= 1'b0;
               o_positive_input_select[ch] <= 1'b0;
               o_negative_input_select[ch] <= 1'b0;
            end else begin
               o_analog_enable[ch]         <= enable[ch];
               o_positive_input_select[ch] <= positive_input_select[ch];
               o_negative_input_select[ch] <= negative_input_select[ch];
            end
         end

         // ***************************
         // settling status
         // ***************************
         // counts the start-up interval after enable so software can poll readiness
         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               settle_count[ch] <= '0;
               o_settled[ch]    <= 1'b0;
            end else if (!enable[ch]) begin
               settle_count[ch] <= '0;
               o_settled[ch]    <= 1'b0;
            end else if (settle_count[ch] != settle_count_t'(`CMP_SETTLE_CYCLES)) begin
               settle_count[ch] <= settle_count[ch] + settle_count_t'(1);
               o_settled[ch]    <= 1'b0;
            end else begin
               o_settled[ch]    <= 1'b1;
            end
         end

         // ***************************
         // interrupt request
         // ***************************
         always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
               o_irq[ch] <= 1'b0;
            end else begin
               o_irq[ch] <= output_change_flag[ch] & i_comparator_irq_enable[ch]
                            & i_global_irq_enable;
            end
         end

      end
   endgenerate

   // ***************************
   // shared reference and wake-up
   // ***************************
   // the internal reference runs whenever an enabled comparator uses it
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_internal_ref_enable <= 1'b0;
      end else begin
         o_internal_ref_enable <= |(enable & negative_input_select);
      end
   end

   // wake only from a reduced power mode, on any enabled pending change
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_wake <= 1'b0;
      end else begin
         o_wake <= (i_idle | i_power_down) & i_global_irq_enable
                   & (|(output_change_flag & i_comparator_irq_enable));
      end
   end

   // ***************************
   // control register images
   // ***************************
   // both registers share one layout; bits 7 and 6 read as zero
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_comparator_one_control <= `CMP_CTRL_RESET;
         o_comparator_two_control <= `CMP_CTRL_RESET;
      end else begin
         o_comparator_one_control <= {2'h0, enable[0], positive_input_select[0],
                                      negative_input_select[0], result_pin_enable[0],
                                      result[0], output_change_flag[0]};
         o_comparator_two_control <= {2'h0, enable[1], positive_input_select[1],
                                      negative_input_select[1], result_pin_enable[1],
                                      result[1], output_change_flag[1]};
      end
   end

endmodule : dual_comparator_control

/* File: include/dual_cmp_cfg.svh */
// field positions, reset values and timing counts of the comparator control block
`ifndef DUAL_CMP_CFG_SVH
`define DUAL_CMP_CFG_SVH

// control register fields, identical for both comparators
`define CMP_FLAG_BIT    0
`define CMP_RESULT_BIT  1
`define CMP_OE_BIT      2
`define CMP_NEG_BIT     3
`define CMP_POS_BIT     4
`define CMP_EN_BIT      5
`define CMP_CTRL_WIDTH  8
`define CMP_CTRL_RESET  8'h00

// clock and settling time
`define CMP_CLK_PERIOD_NS  25
`define CMP_SETTLE_NS      10000
`define CMP_SETTLE_CYCLES  ((`CMP_SETTLE_NS + `CMP_CLK_PERIOD_NS - 1) / `CMP_CLK_PERIOD_NS)
`define CMP_SETTLE_WIDTH   9

`endif

/* File: include/dual_cmp_pkg.sv */
// types shared by the comparator control block
package dual_cmp_pkg;

   typedef logic [7:0] cmp_ctrl_t;

   typedef logic [8:0] settle_count_t;

   typedef enum logic {
      POS_PIN_A = 1'b0,
      POS_PIN_B = 1'b1
   } pos_src_t;

   typedef enum logic {
      NEG_EXT_PIN      = 1'b0,
      NEG_INTERNAL_REF = 1'b1
   } neg_src_t;

   // positive choice, negative choice, pin enable: one of eight configurations
   typedef logic [2:0] cmp_config_t;

endpackage : dual_cmp_pkg

/* File: src/comparator_input_sync.sv */
// synchroniser for one raw comparator output into the cpu clock domain
`timescale 1ns/1ps
module comparator_input_sync (
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   input  wire logic i_raw,
   output logic      o_level
);

   logic stage_one;
   logic stage_two;
   logic stage_three;

   // ***************************
   // synchroniser chain
   // ***************************
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         stage_one   <= 1'b0;
         stage_two   <= 1'b0;
         stage_three <= 1'b0;
      end else begin
         stage_one   <= i_raw;
         stage_two   <= stage_one;
         stage_three <= stage_two;
      end
   end

   // ***************************
   // accepted level
   // ***************************
   // a change counts only once the second and third stages agree
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_level <= 1'b0;
      end else if (stage_two == stage_three) begin
         o_level <= stage_three;
      end
   end

endmodule : comparator_input_sync

/* File: testbench/analog_front_model.sv */
// behavioural analog front end: two comparators with input muxes and a reference
`timescale 1ns/1ps
module analog_front_model #(
   parameter logic [11:0] REF_MV = 12'h500
) (
   input  wire logic [1:0]       i_analog_enable,
   input  wire logic [1:0]       i_positive_input_select,
   input  wire logic [1:0]       i_negative_input_select,
   input  wire logic             i_internal_ref_enable,
   input  wire logic [1:0][11:0] i_pos_a_mv,
   input  wire logic [1:0][11:0] i_pos_b_mv,
   input  wire logic [1:0][11:0] i_neg_pin_mv,
   output logic [1:0]            o_raw
);
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         o_raw[k] = i_analog_enable[k] &&
            ((i_positive_input_select[k] ? i_pos_b_mv[k] : i_pos_a_mv[k]) >
             (i_negative_input_select[k] ? (i_internal_ref_enable ? REF_MV : 12'hfff)
                                         : i_neg_pin_mv[k]));
      end
   end
endmodule : analog_front_model

/* File: testbench/dual_comparator_control_chk.sv */
// port assertions for the comparator control block
`timescale 1ns/1ps
module dual_comparator_control_chk (
   input wire logic       i_clk,
   input wire logic       i_arst_n,
   input wire logic [1:0] i_comparator_irq_enable,
   input wire logic       i_global_irq_enable,
   input wire logic [7:0] o_comparator_one_control,
   input wire logic [7:0] o_comparator_two_control,
   input wire logic [1:0] o_analog_enable,
   input wire logic [1:0] o_positive_input_select,
   input wire logic [1:0] o_negative_input_select,
   input wire logic       o_internal_ref_enable,
   input wire logic [1:0] o_result_pin,
   input wire logic [1:0] o_result_pin_oe,
   input wire logic [1:0] o_irq,
   input wire logic       o_wake,
   input wire logic [1:0] o_settled
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   logic [1:0][7:0] img;
   logic [1:0][9:0] on_cnt;
   assign img[0] = o_comparator_one_control;
   assign img[1] = o_comparator_two_control;
   // cycles each comparator has been enabled, saturating
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         on_cnt <= '0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            on_cnt[k] <= !o_analog_enable[k] ? 10'h000 :
                         (on_cnt[k] == 10'h3ff) ? on_cnt[k] : on_cnt[k] + 10'h001;
         end
      end
   end
   for (genvar i = 0; i < 2; i++) begin : g_cmp
      chk_irq_gate_flag: assert property (o_irq[i] |-> img[i][0] &&
         $past(i_comparator_irq_enable[i]) && $past(i_global_irq_enable)) else $error("irq ungated");
      chk_pin_drive_map: assert property (o_result_pin_oe[i] == (img[i][5] && img[i][2]))
         else $error("pin enable mismatch");
      chk_enable_map: assert property (o_analog_enable[i] == img[i][5])
         else $error("enable mismatch");
      chk_input_select_map: assert property ($stable(img[i][5:2]) [*3] |->
         o_positive_input_select[i] == img[i][4] && o_negative_input_select[i] == img[i][3])
         else $error("select mismatch");
      chk_change_sets_flag: assert property ($changed(img[i][1]) |-> img[i][0])
         else $error("change without flag");
      chk_disabled_result_low: assert property (!img[i][5] [*3] |-> !img[i][1])
         else $error("disabled result high");
      chk_pin_follows_result: assert property ($rose(o_result_pin[i]) |-> ##[0:2] img[i][1])
         else $error("pin without result");
      chk_settle_time: assert property ($rose(o_settled[i]) |-> on_cnt[i] inside {[395:402]})
         else $error("settle time off");
   end
   chk_ref_enable_map: assert property ($stable(img) [*3] |-> o_internal_ref_enable ==
      ((img[0][5] && img[0][3]) || (img[1][5] && img[1][3]))) else $error("reference mismatch");
   cover property ($rose(o_irq[0]));
   cover property ($rose(o_wake));
   cover property ($rose(o_settled[1]));
endmodule : dual_comparator_control_chk
bind dual_comparator_control dual_comparator_control_chk dual_comparator_control_chk_i (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_comparator_irq_enable(i_comparator_irq_enable),
   .i_global_irq_enable(i_global_irq_enable), .o_comparator_one_control(o_comparator_one_control),
   .o_comparator_two_control(o_comparator_two_control), .o_analog_enable(o_analog_enable),
   .o_positive_input_select(o_positive_input_select), .o_wake(o_wake), .o_settled(o_settled),
   .o_negative_input_select(o_negative_input_select), .o_internal_ref_enable(o_internal_ref_enable),
   .o_result_pin(o_result_pin), .o_result_pin_oe(o_result_pin_oe), .o_irq(o_irq));

/* File: testbench/dual_comparator_control_bench.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module dual_comparator_control_bench;
   logic             clk = 1'b0, arst_n = 1'b0, wr1 = 1'b0, wr2 = 1'b0, gie = 1'b0;
   logic             idle = 1'b0, pd = 1'b0, refen, wake;
   logic [7:0]       wdata = 8'h00, img1, img2;
   logic [1:0]       ien = 2'h0, raw, en, psel, nsel, pin, oe, irq, settled;
   logic [1:0][11:0] pos_a = '0, pos_b = '0, neg_pin = '0;
   int               failures = 0, checked = 0;
   always #12.5 clk = ~clk;
   dual_comparator_control dual_comparator_control_i (.i_clk(clk), .i_arst_n(arst_n),
      .i_comparator_one_control_wr(wr1), .i_comparator_two_control_wr(wr2),
      .i_control_wdata(wdata), .i_analog_result(raw), .i_comparator_irq_enable(ien),
      .i_global_irq_enable(gie), .i_idle(idle), .i_power_down(pd),
      .o_comparator_one_control(img1), .o_comparator_two_control(img2), .o_analog_enable(en),
      .o_positive_input_select(psel), .o_negative_input_select(nsel),
      .o_internal_ref_enable(refen), .o_result_pin(pin), .o_result_pin_oe(oe), .o_irq(irq),
      .o_wake(wake), .o_settled(settled));
   analog_front_model analog_front_model_i (.i_analog_enable(en), .i_positive_input_select(psel),
      .i_negative_input_select(nsel), .i_internal_ref_enable(refen), .i_pos_a_mv(pos_a),
      .i_pos_b_mv(pos_b), .i_neg_pin_mv(neg_pin), .o_raw(raw));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input int which, input logic [7:0] d);
      @(posedge clk);
      wr1 <= (which == 1);
      wr2 <= (which == 2);
      wdata <= d;
      @(posedge clk);
      wr1 <= 1'b0;
      wr2 <= 1'b0;
   endtask : wr
   task automatic summarize();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   initial begin
      #(25 * 3000);
      failures++;
      summarize();
   end
   initial begin
      logic [7:0] d;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      pos_a <= {12'h064, 12'h064};
      pos_b <= {12'h0c8, 12'h0c8};
      neg_pin <= {12'h096, 12'h096};
      tick(1);
      chk(img1, 8'h00);
      chk({img2[7:2], oe}, 8'h00);
      wr(1, 8'h24);
      tick(2);
      chk(img1, 8'h24);
      chk({4'h0, oe[0], en[0], psel[0], nsel[0]}, 8'h0c);
      for (int c = 0; c < 8; c++) begin
         d = {3'b001, 3'(c), 2'b00};
         wr(2, d);
         tick(8);
         chk(img2 & 8'hfe, d | {6'h00, d[4] & ~d[3], 1'b0});
         chk({7'h00, pin[1]}, {7'h00, d[4] & ~d[3]});
         chk({3'h0, oe[1], en[1], psel[1], nsel[1], refen}, {3'h0, d[2], 1'b1, d[4], d[3], d[3]});
      end
      wr(2, 8'h00);
      tick(8);
      chk(img2 & 8'hfe, 8'h00);
      @(posedge clk);
      pos_a[0] <= 12'h0c8;
      tick(8);
      chk(img1, 8'h27);
      chk({7'h00, pin[0]}, 8'h01);
      wr(1, 8'h25);
      tick(2);
      chk(img1, 8'h27);
      wr(1, 8'h24);
      tick(2);
      chk(img1, 8'h26);
      @(posedge clk);
      pos_a[0] <= 12'h064;
      tick(8);
      chk(img1, 8'h25);
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         ien[0] <= m[0];
         gie <= m[1];
         tick(3);
         chk({7'h00, irq[0]}, {7'h00, m[0] & m[1]});
      end
      wr(1, 8'h24);
      tick(3);
      chk({6'h00, irq}, 8'h00);
      @(posedge clk);
      pd <= 1'b1;
      pos_a[0] <= 12'h0c8;
      tick(8);
      chk({6'h00, wake, irq[0]}, 8'h03);
      chk(img1, 8'h27);
      chk({6'h00, oe[0], pin[0]}, 8'h03);
      @(posedge clk);
      pd <= 1'b0;
      idle <= 1'b1;
      tick(3);
      chk({7'h00, wake}, 8'h01);
      @(posedge clk);
      idle <= 1'b0;
      tick(3);
      chk({7'h00, wake}, 8'h00);
      wr(2, 8'h28);
      tick(385);
      chk({7'h00, settled[1]}, 8'h00);
      tick(25);
      chk({6'h00, settled}, 8'h03);
      wr(2, 8'h28);
      @(posedge clk);
      ien[1] <= 1'b1;
      tick(3);
      chk({7'h00, irq[1]}, 8'h00);
      @(posedge clk);
      pos_a[1] <= 12'h5dc;
      tick(8);
      chk({7'h00, irq[1]}, 8'h01);
      wr(2, 8'h28);
      tick(3);
      chk({7'h00, irq[1]}, 8'h00);
      @(posedge clk);
      arst_n <= 1'b0;
      tick(1);
      chk(img1 | img2, 8'h00);
      chk({oe, irq, en}, 8'h00);
      summarize();
   end
endmodule : dual_comparator_control_bench
